// [pmpd_pkg.sv]
package pmpd_pkg;

    // ------------------------------------------------------------
    // Widths and geometry
    // ------------------------------------------------------------
    localparam int ADDR_W     = 32;
    localparam int DATA_W     = 256;
    localparam int WORD_LSB   = 5;
    localparam int ERR_ADDR_W = 27;
    localparam int PAR_IDX_W  = 10;
    localparam int PAR_DEPTH  = 1024;
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;

    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [REG_ADDR_W-1:0] OFS_STATUS   = 8'h04;
    localparam logic [REG_ADDR_W-1:0] OFS_COMMAND  = 8'h08;
    localparam logic [REG_ADDR_W-1:0] OFS_ERR_ADDR = 8'h0c;

    localparam int BIT_ON       = 0;
    localparam int BIT_OFF      = 2;
    localparam int BIT_HOLD     = 3;
    localparam int BIT_FERR     = 5;
    localparam int BIT_TERR     = 6;
    localparam int BIT_RAM      = 0;
    localparam int ERR_ADDR_LSB = 5;

    // Default event line at the interrupt and exception controller
    localparam logic [6:0] EVENT_NUM_DEFAULT = 7'h71;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {MODE_OFF, MODE_ON, MODE_HOLD} pmpd_mode_t;

    typedef struct packed {
        logic valid;
        logic parity;
    } pmpd_entry_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              full;
        logic              debug;
    } pmpd_wr_t;

    typedef struct packed {
        logic              valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic              full;
        logic              fetch;
        logic              debug;
        logic              ram;
    } pmpd_rd_t;

    typedef struct packed {
        pmpd_mode_t            mode;
        logic                  ferr;
        logic                  terr;
        logic [ERR_ADDR_W-1:0] err_addr;
        logic                  err_ram;
        logic                  chk_v;
        logic                  chk_fetch;
        logic                  chk_par;
        logic [ERR_ADDR_W-1:0] chk_addr;
        logic                  chk_ram;
        logic                  fetch_err;
        logic                  xfer_err;
        logic [REG_DATA_W-1:0] rdata;
    } pmpd_state_t;

    localparam pmpd_state_t ST_RESET = pmpd_state_t'('0);

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    function automatic logic calc_parity(input logic [DATA_W-1:0] d);
        return ^d;
    endfunction

    function automatic logic [PAR_IDX_W-1:0] word_index(input logic [ADDR_W-1:0] a);
        return a[WORD_LSB +: PAR_IDX_W];
    endfunction

    function automatic logic is_full_word(input logic full, input logic [ADDR_W-1:0] a);
        return full && (a[WORD_LSB-1:0] == '0);
    endfunction

endpackage

// [pmpd_par_mem.sv]
`timescale 1ns/10ps
module pmpd_par_mem
    import pmpd_pkg::*;
(
    // Clock
    input  logic                 clk,
    // Write side
    input  logic                 we,
    input  logic [PAR_IDX_W-1:0] waddr,
    input  pmpd_entry_t          wdata,
    // Read side, data one cycle later
    input  logic [PAR_IDX_W-1:0] raddr,
    output pmpd_entry_t          rdata
);

    pmpd_entry_t mem [PAR_DEPTH];

    // No reset: stale entries are neutralised by valid clearing, not by a sweep
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// [pmpd_detect.sv]
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
module pmpd_detect
    import pmpd_pkg::*;
(
    // Clock and reset
    input  logic                  CLK,
    input  logic                  RST,
    // Register port
    input  logic [REG_ADDR_W-1:0] REG_ADDR,
    input  logic [REG_DATA_W-1:0] REG_WDATA,
    input  logic                  REG_WR,
    input  logic                  REG_RD,
    output logic [REG_DATA_W-1:0] REG_RDATA,
    // Program memory accesses
    input  pmpd_wr_t              WR,
    input  pmpd_rd_t              RD,
    // Error outputs
    output logic                  FETCH_ERR,
    output logic                  XFER_ERR,
    output logic [6:0]            XFER_EVENT_NUM
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    pmpd_state_t st_r;
    pmpd_state_t st_nxt;
    pmpd_entry_t ent;
    pmpd_entry_t mem_wd;
    logic        mem_we;
    logic        cmd_wr;
    logic        par_err;
    logic [2:0]  mode_bits;

    function automatic logic [1:0] bit_count(input logic [2:0] b);
        return 2'(b[0]) + 2'(b[1]) + 2'(b[2]);
    endfunction

    // ------------------------------------------------------------
    // Parity storage
    // ------------------------------------------------------------
    pmpd_par_mem pmpd_par_mem_i (
        .clk   (CLK),
        .we    (mem_we),
        .waddr (word_index(WR.addr)),
        .wdata (mem_wd),
        .raddr (word_index(RD.addr)),
        .rdata (ent)
    );

    always_comb begin
        mem_we = 1'b0;
        mem_wd = '0;
        if (WR.valid) begin
            unique case (st_r.mode)
                MODE_OFF: begin
                    mem_we = 1'b1;
                end
                // full word stores parity, narrow or debug invalidates
                MODE_ON: begin
                    mem_we = 1'b1;
                    if (is_full_word(WR.full, WR.addr) && !WR.debug) begin
                        mem_wd.valid  = 1'b1;
                        mem_wd.parity = calc_parity(WR.data);
                    end
                end
                MODE_HOLD: begin
                    mem_we = 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control, check pipeline and registers
    // ------------------------------------------------------------
    assign cmd_wr    = REG_WR && (REG_ADDR == OFS_COMMAND);
    assign mode_bits = {REG_WDATA[BIT_HOLD], REG_WDATA[BIT_OFF], REG_WDATA[BIT_ON]};
    assign par_err   = st_r.chk_v && ent.valid && (ent.parity != st_r.chk_par);

    always_comb begin
        st_nxt           = st_r;
        st_nxt.fetch_err = 1'b0;
        st_nxt.xfer_err  = 1'b0;
        st_nxt.rdata     = '0;

        if (cmd_wr) begin
            if (bit_count(mode_bits) > 2'd1) begin
                st_nxt.mode = MODE_OFF;
            end else if (REG_WDATA[BIT_ON]) begin
                st_nxt.mode = MODE_ON;
            end else if (REG_WDATA[BIT_OFF]) begin
                st_nxt.mode = MODE_OFF;
            end else if (REG_WDATA[BIT_HOLD]) begin
                st_nxt.mode = MODE_HOLD;
            end
            if (REG_WDATA[BIT_FERR]) begin
                st_nxt.ferr = 1'b0;
            end
            if (REG_WDATA[BIT_TERR]) begin
                st_nxt.terr = 1'b0;
            end
        end

        // only enabled full non-debug reads enter the check
        st_nxt.chk_v     = RD.valid && is_full_word(RD.full, RD.addr) && !RD.debug
                           && (st_r.mode == MODE_ON);
        st_nxt.chk_fetch = RD.fetch;
        // XOR reduction of the read word
        st_nxt.chk_par   = calc_parity(RD.data);
        st_nxt.chk_addr  = RD.addr[ADDR_W-1:ERR_ADDR_LSB];
        st_nxt.chk_ram   = RD.ram;

        // Error capture after clears, but gated by the old flags, so an error of a kind being cleared is dropped
        if (par_err) begin
            // fetch error overrides a recorded transfer error
            if (st_r.chk_fetch && !st_r.ferr) begin
                st_nxt.ferr     = 1'b1;
                st_nxt.terr     = 1'b0;
                st_nxt.err_addr = st_r.chk_addr;
                // memory type of the failing word
                st_nxt.err_ram  = st_r.chk_ram;
                // immediate exception pulse to the CPU
                st_nxt.fetch_err = 1'b1;
            end else if (!st_r.chk_fetch && !st_r.ferr && !st_r.terr) begin
                st_nxt.terr     = 1'b1;
                st_nxt.err_addr = st_r.chk_addr;
                st_nxt.err_ram  = st_r.chk_ram;
                // event to the interrupt and exception controller
                st_nxt.xfer_err = 1'b1;
            end
        end

        if (REG_RD) begin
            unique case (REG_ADDR)
                // one-hot mode and single error flag
                OFS_STATUS: begin
                    st_nxt.rdata[BIT_ON]   = (st_r.mode == MODE_ON);
                    st_nxt.rdata[BIT_OFF]  = (st_r.mode == MODE_OFF);
                    st_nxt.rdata[BIT_HOLD] = (st_r.mode == MODE_HOLD);
                    st_nxt.rdata[BIT_FERR] = st_r.ferr;
                    st_nxt.rdata[BIT_TERR] = st_r.terr;
                end
                OFS_ERR_ADDR: begin
                    st_nxt.rdata[ADDR_W-1:ERR_ADDR_LSB] = st_r.err_addr;
                    st_nxt.rdata[BIT_RAM]               = st_r.err_ram;
                end
                default: begin
                    st_nxt.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // separate CPU and controller error lines
    assign FETCH_ERR      = st_r.fetch_err;
    assign XFER_ERR       = st_r.xfer_err;
    assign XFER_EVENT_NUM = EVENT_NUM_DEFAULT;
    assign REG_RDATA      = st_r.rdata;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_mode_off: assert property (
        @(posedge CLK) disable iff (RST) $past(RST) |-> st_r.mode == MODE_OFF)
        else $error("mode not disabled after reset");

    a_off_no_check: assert property (
        @(posedge CLK) disable iff (RST)
        (RD.valid && st_r.mode != MODE_ON) |-> ##2 !(FETCH_ERR || XFER_ERR))
        else $error("read checked outside enabled mode");

    a_enable_cmd: assert property (
        @(posedge CLK) disable iff (RST)
        (cmd_wr && mode_bits == 3'h1) |=> st_r.mode == MODE_ON)
        else $error("enable command ignored");

    a_narrow_invalid: assert property (
        @(posedge CLK) disable iff (RST)
        (WR.valid && st_r.mode == MODE_ON && !WR.full) |-> (mem_we && !mem_wd.valid))
        else $error("narrow write left parity valid");

    a_hold_untouched: assert property (
        @(posedge CLK) disable iff (RST)
        (cmd_wr && mode_bits == 3'h4) |=> (st_r.mode == MODE_HOLD) && !mem_we)
        else $error("suspend did not freeze storage");

    a_fetch_latency: assert property (
        @(posedge CLK) disable iff (RST)
        FETCH_ERR |-> $past(RD.valid && RD.fetch, 2) && st_r.ferr)
        else $error("fetch error not two cycles after fetch");

    a_first_only: assert property (
        @(posedge CLK) disable iff (RST)
        XFER_ERR |-> $past(!st_r.ferr && !st_r.terr) && st_r.terr)
        else $error("transfer error signalled while one recorded");

    a_fetch_override: assert property (
        @(posedge CLK) disable iff (RST)
        (par_err && st_r.chk_fetch && st_r.terr) |=> FETCH_ERR && st_r.ferr && !st_r.terr)
        else $error("fetch error did not replace transfer error");

    a_debug_unchecked: assert property (
        @(posedge CLK) disable iff (RST)
        (RD.valid && RD.debug) |-> ##2 !(FETCH_ERR || XFER_ERR))
        else $error("debug read was checked");

    a_status_onehot: assert property (
        @(posedge CLK) disable iff (RST) !(st_r.ferr && st_r.terr))
        else $error("both error flags set");

    a_multi_mode_off: assert property (
        @(posedge CLK) disable iff (RST)
        (cmd_wr && bit_count(mode_bits) > 2'd1) |=> st_r.mode == MODE_OFF)
        else $error("multi mode write not disabled");

    a_off_clears: assert property (
        @(posedge CLK) disable iff (RST)
        (WR.valid && st_r.mode == MODE_OFF) |-> (mem_we && !mem_wd.valid))
        else $error("disabled write left parity valid");

    a_full_store: assert property (
        @(posedge CLK) disable iff (RST)
        (WR.valid && st_r.mode == MODE_ON && !WR.debug && WR.full
         && WR.addr[WORD_LSB-1:0] == '0)
        |-> (mem_we && mem_wd.valid && mem_wd.parity == ^WR.data))
        else $error("full write did not store parity");

    a_error_reported: assert property (
        @(posedge CLK) disable iff (RST)
        par_err |=> (FETCH_ERR || XFER_ERR || $past(st_r.ferr || st_r.terr)))
        else $error("parity mismatch not reported");

    a_hold_no_write: assert property (
        @(posedge CLK) disable iff (RST)
        (WR.valid && st_r.mode == MODE_HOLD) |-> !mem_we)
        else $error("suspended write touched parity");

    a_disable_cmd: assert property (
        @(posedge CLK) disable iff (RST)
        (cmd_wr && mode_bits == 3'h2) |=> st_r.mode == MODE_OFF)
        else $error("disable command ignored");

    a_debug_invalid: assert property (
        @(posedge CLK) disable iff (RST)
        (WR.valid && WR.debug && st_r.mode != MODE_HOLD) |-> (mem_we && !mem_wd.valid))
        else $error("debug write left parity valid");

    a_err_ram_type: assert property (
        @(posedge CLK) disable iff (RST)
        (FETCH_ERR || XFER_ERR) |-> st_r.err_ram == $past(RD.ram, 2))
        else $error("memory type of error not captured");

    a_err_addr_word: assert property (
        @(posedge CLK) disable iff (RST)
        (FETCH_ERR || XFER_ERR) |-> st_r.err_addr == $past(RD.addr[ADDR_W-1:ERR_ADDR_LSB], 2))
        else $error("error word address not captured");

    a_valid_mismatch: assert property (
        @(posedge CLK) disable iff (RST)
        (FETCH_ERR || XFER_ERR)
        |-> ($past(ent.valid) && $past(ent.parity) != $past(^RD.data, 2)))
        else $error("error without valid mismatching parity");

endmodule

// [pmpd_mem_model.sv]
`timescale 1ns/10ps
module pmpd_mem_model
    import pmpd_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Access stream into the detector
    output pmpd_wr_t  wr,
    output pmpd_rd_t  rd
);
    logic [DATA_W-1:0] mem [PAR_DEPTH];

    initial begin
        wr = '0;
        rd = '0;
    end

    // Released lines show inverted data so a stale copy never looks valid
    task automatic put(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic full, input logic dbg);
        @(posedge clk);
        wr <= '{1'b1, a, d, full, dbg};
        mem[a[WORD_LSB +: PAR_IDX_W]] = d;
        @(posedge clk);
        wr <= '{1'b0, ~a, ~d, 1'b0, 1'b0};
    endtask

    task automatic get(input logic [ADDR_W-1:0] a, input logic fetch, input logic ram,
                       input logic dbg);
        logic [DATA_W-1:0] d;
        d = mem[a[WORD_LSB +: PAR_IDX_W]];
        @(posedge clk);
        rd <= '{1'b1, a, d, !dbg, fetch, dbg, ram};
        @(posedge clk);
        rd <= '{1'b0, ~a, ~d, 1'b0, 1'b0, 1'b0, 1'b0};
    endtask
endmodule

// [program_memory_parity_detect_bench.sv]
`timescale 1ns/10ps
module program_memory_parity_detect_bench
    import pmpd_pkg::*;
;
    logic                  clk;
    logic                  rst;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [REG_DATA_W-1:0] reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [REG_DATA_W-1:0] reg_rdata;
    pmpd_wr_t              wr;
    pmpd_rd_t              rd;
    logic                  fetch_err;
    logic                  xfer_err;
    logic [6:0]            event_num;
    int                    miscompares;
    int                    cmp_count;
    int                    cyc;
    localparam logic [ADDR_W-1:0] wa = 32'h0020_1240;
    localparam logic [ADDR_W-1:0] wb = 32'h0020_1260;
    localparam logic [DATA_W-1:0] dw = {8{32'h5a5a_0001}};

    pmpd_detect pmpd_detect_i (
        .CLK(clk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .WR(wr), .RD(rd),
        .FETCH_ERR(fetch_err), .XFER_ERR(xfer_err), .XFER_EVENT_NUM(event_num)
    );
    pmpd_mem_model pmpd_mem_model_i (.clk(clk), .wr(wr), .rd(rd));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_w(input logic [REG_ADDR_W-1:0] a, input logic [REG_DATA_W-1:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_chk(input logic [REG_ADDR_W-1:0] a, input logic [REG_DATA_W-1:0] e);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk($sformatf("register %h", a), reg_rdata, e);
    endtask

    task automatic mw(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic full, input logic dbg);
        pmpd_mem_model_i.put(a, d, full, dbg);
    endtask

    // Error pulses are looked for in the cycle after the take and the one after that
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic fetch, input logic ram,
                          input logic dbg, input logic ef, input logic ex);
        pmpd_mem_model_i.get(a, fetch, ram, dbg);
        #1;
        chk("fetch error early", {31'h0, fetch_err}, 32'h0);
        chk("transfer error early", {31'h0, xfer_err}, 32'h0);
        @(posedge clk);
        #1;
        chk("fetch error", {31'h0, fetch_err}, {31'h0, ef});
        chk("transfer error", {31'h0, xfer_err}, {31'h0, ex});
    endtask

    task automatic report_and_stop();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock and timeout
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst         = 1'b1;
        reg_addr    = '0;
        reg_wdata   = '0;
        reg_wr      = 1'b0;
        reg_rd      = 1'b0;
        miscompares = 0;
        cmp_count   = 0;
        cyc         = 0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        reg_chk(OFS_STATUS, 32'h0000_0004);
        reg_chk(OFS_ERR_ADDR, 32'h0);
        chk("event number", {25'h0, event_num}, 32'h0000_0071);
        reg_chk(OFS_COMMAND, 32'h0);
        reg_chk(8'h10, 32'h0);
        reg_w(OFS_STATUS, 32'h0000_0001);
        reg_chk(OFS_STATUS, 32'h0000_0004);
        reg_w(OFS_COMMAND, 32'h0000_0001);
        reg_chk(OFS_STATUS, 32'h0000_0001);
        mw(wa, dw, 1'b1, 1'b0);
        rd_chk(wa, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        // Disabled writes drop validity of a good entry
        mw(wb, dw, 1'b1, 1'b0);
        reg_w(OFS_COMMAND, 32'h0000_0004);
        mw(wb, dw ^ 256'h1, 1'b1, 1'b0);
        rd_chk(wb, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        reg_w(OFS_COMMAND, 32'h0000_0001);
        rd_chk(wb, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        mw(wb, dw, 1'b1, 1'b0);
        mw(wb, dw ^ 256'h1, 1'b0, 1'b0);
        rd_chk(wb, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        mw(wb, dw, 1'b1, 1'b0);
        mw(wb, dw ^ 256'h1, 1'b1, 1'b1);
        rd_chk(wb, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        // Suspended writes plant corrupt data under a valid entry
        reg_w(OFS_COMMAND, 32'h0000_0008);
        mw(wa, dw ^ 256'h3, 1'b1, 1'b0);
        reg_w(OFS_COMMAND, 32'h0000_0001);
        rd_chk(wa, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        reg_w(OFS_COMMAND, 32'h0000_0008);
        mw(wa, dw ^ 256'h2, 1'b1, 1'b0);
        mw(wa, dw ^ 256'h2, 1'b1, 1'b1);
        reg_chk(OFS_STATUS, 32'h0000_0008);
        rd_chk(wa, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        reg_w(OFS_COMMAND, 32'h0000_0004);
        reg_chk(OFS_STATUS, 32'h0000_0004);
        reg_w(OFS_COMMAND, 32'h0000_0001);
        rd_chk(wa, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        rd_chk(wa, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        reg_chk(OFS_STATUS, 32'h0000_0021);
        reg_chk(OFS_ERR_ADDR, wa | 32'h1);
        rd_chk(wa, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        rd_chk(wa, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        reg_w(OFS_COMMAND, 32'h0000_0020);
        reg_chk(OFS_STATUS, 32'h0000_0001);
        rd_chk(wa, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        reg_chk(OFS_STATUS, 32'h0000_0041);
        reg_chk(OFS_ERR_ADDR, wa);
        rd_chk(wa, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
        reg_chk(OFS_STATUS, 32'h0000_0021);
        reg_chk(OFS_ERR_ADDR, wa | 32'h1);
        // Mid-run reset with a flag set: status clears, parity storage survives
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        reg_chk(OFS_STATUS, 32'h0000_0004);
        reg_chk(OFS_ERR_ADDR, 32'h0);
        reg_w(OFS_COMMAND, 32'h0000_0001);
        rd_chk(wa, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
        reg_chk(OFS_STATUS, 32'h0000_0041);
        reg_chk(OFS_ERR_ADDR, wa | 32'h1);
        reg_w(OFS_COMMAND, 32'h0000_006d);
        reg_chk(OFS_STATUS, 32'h0000_0004);
        report_and_stop();
    end
endmodule
